// File: core/mmci_core.sv
// mailbox command interpreter with an ahb-lite register slave
// assumes a single-word ahb-lite master and modem datapath around it
//
// Notes on behaviour
// - three bytes, opcode in byte zero
// - no-op keeps state and running handshake
// - initialize restores defaults, then idles
// - handshake runs and reports its outcome
// - retrain starts retrain sequence
// - freeze opcodes stop or resume adaptation
// - scrambler command; handshake end enables both
// - gain factor scales every transmit sample
// - fax receiver sync and transmitter stop
// - serial mode routes data via converter
// - serial mode may lengthen exchange period
// - store with or without pointer increment
// - load pointer and return addressed word
// - load pointer, return two upper bytes
// - separate opcodes select modem families
// - front-end configure passes both bytes
// - front-end register reads and writes
// - tone select programs but never enables
// - tone define loads phase increment
// - generator enable; tone two louder
// - data over answer over general status
// - two type bits mark answer content
// - call, handshake, data phase sequencing
`timescale 1ns/1ps
module mmci_core
  import mmci_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYC_DEF,
  parameter int unsigned NOM_CYC = NOM_CYC_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] det_status,
  input wire logic [3:0] line_flags,
  input wire logic c107_req,
  input wire logic hs_done,
  input wire logic hs_fail,
  input wire logic far_retrain,
  input wire logic [11:0] fe_read_a,
  input wire logic [11:0] fe_read_b,
  input wire logic [15:0] tx_sample,
  output logic [15:0] tx_sample_out,
  output logic [1:0] phase,
  output logic hs_start,
  output logic retrain_start,
  output logic ec_freeze,
  output logic eq_freeze,
  output logic scram_tx_en,
  output logic scram_rx_en,
  output logic fax_sync,
  output logic fax_stop,
  output logic serial_mode,
  output logic [15:0] serial_cfg,
  output logic send_valid,
  output logic [15:0] send_bytes,
  output logic [1:0] mode_sel,
  output logic [15:0] mode_cfg,
  output logic fe_cfg_stb,
  output logic fe_wr_a_stb,
  output logic fe_wr_b_stb,
  output logic [15:0] fe_data,
  output logic [7:0] tone_sel,
  output logic [15:0] gen1_inc,
  output logic [15:0] gen2_inc,
  output logic [1:0] gen_en,
  output logic [3:0] gen1_atten_db
);

  function automatic mmci_cmd_t classify(input logic [23:0] c);
    mmci_cmd_t k;
    k = C_NOP;
    case (c)
      OP_INIT: k = C_INIT;
      OP_BEGIN_LINK_NEGOTIATION: k = C_BEGIN_LINK_NEGOTIATION;
      OP_RESTART_TRAINING_CMD: k = C_RESTART_TRAINING_CMD;
      OP_FRZ_EC: k = C_FRZ_EC;
      OP_UFZ_EC: k = C_UFZ_EC;
      OP_FRZ_EQ: k = C_FRZ_EQ;
      OP_UFZ_EQ: k = C_UFZ_EQ;
      OP_FE_RD_A: k = C_FE_RD_A;
      OP_FE_RD_B: k = C_FE_RD_B;
      default: begin
        case (c[23:16])
          OP_SEND: k = C_SEND;
          OP_GAIN: k = C_GAIN;
          OP_FE_CFG: k = C_FE_CFG;
          OP_FE_WR_A: k = C_FE_WR_A;
          OP_FE_WR_B: k = C_FE_WR_B;
          OP_TONE_SEL: k = C_TONE_SEL;
          OP_TONE_EN: k = C_TONE_EN;
          OP_DEF_G1: k = C_DEF_G1;
          OP_DEF_G2: k = C_DEF_G2;
          OP_RD_PTR: k = C_RD_PTR;
          OP_RD_PAIR: k = C_RD_PAIR;
          OP_STORE: k = C_STORE;
          OP_STORE_INC: k = C_STORE_INC;
          OP_SERIAL: k = C_SERIAL;
          OP_SCRAM: k = C_SCRAM;
          OP_FAX_STOP: k = C_FAX_STOP;
          OP_FAX_SYNC: k = C_FAX_SYNC;
          OP_CFG_FSK, OP_CFG_MID, OP_CFG_FAX, OP_CFG_HIGH: k = C_CFG;
          default: k = C_NOP;
        endcase
      end
    endcase
    return k;
  endfunction

  mmci_mem_if mif ();

  mmci_mem u_mem (
    .hclk(hclk),
    .mif(mif)
  );

  logic wr_pend_r;
  logic [7:0] wr_off_r;
  logic rd_hit;
  logic exch;
  logic [23:0] cmd;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  mmci_cmd_t kind;
  logic [15:0] ptr_r;
  logic rx_pend_r;
  logic [7:0] rx_hold_r;
  logic ans_pend_r;
  logic [7:0] ans_b1_r;
  logic [7:0] ans_b2_r;
  logic [23:0] rsp_r;
  logic [23:0] cmd_last_r;
  logic exch_req_r;
  logic hs_fail_r;
  logic [31:0] per_cnt_r;
  logic [31:0] ms_cnt_r;
  logic ms_en;
  logic [31:0] per_lim;
  mmci_phase_t phase_r;

  assign cmd = hwdata[23:0];
  assign b0 = cmd[23:16];
  assign b1 = cmd[15:8];
  assign b2 = cmd[7:0];
  assign exch = wr_pend_r && (wr_off_r == OFF_CMD);
  assign kind = classify(cmd);
  assign rd_hit = hsel && htrans[1] && hready && !hwrite;

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_off_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_r <= hsel && htrans[1] && hwrite;
        wr_off_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_hit) begin
      case (haddr[7:0])
        OFF_CMD: hrdata <= {8'h00, cmd_last_r};
        OFF_RSP: hrdata <= {8'h00, rsp_r};
        OFF_STAT: begin
          hrdata <= 32'h00000000;
          hrdata[ST_EXCH_REQ] <= exch_req_r;
          hrdata[ST_SERIAL] <= serial_mode;
          hrdata[ST_PHASE_LO +: 2] <= phase_r;
          hrdata[ST_HS_FAIL] <= hs_fail_r;
          hrdata[ST_ANS_PEND] <= ans_pend_r;
          hrdata[ST_RX_PEND] <= rx_pend_r;
        end
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // memory port
  // store at pointer
  assign mif.we = exch && (kind == C_STORE || kind == C_STORE_INC);
  assign mif.waddr = ptr_r[7:0];
  assign mif.wdata = {b2, b1};
  assign mif.raddr = (kind == C_RD_PTR || kind == C_RD_PAIR) ? b1 : ptr_r[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_r <= 16'h0000;
    end else if (exch) begin
      if (kind == C_STORE_INC) begin
        ptr_r <= 16'(ptr_r + 16'h0001);
      end else if (kind == C_RD_PTR || kind == C_RD_PAIR) begin
        ptr_r <= {b2, b1};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_r <= 24'h000000;
      cmd_last_r <= 24'h000000;
    end else if (exch) begin
      cmd_last_r <= cmd;
      rsp_r[23:16] <= {line_flags, 4'h0};
      rsp_r[16 + RB_BEGIN_LINK_NEGOTIATION] <= (phase_r == PH_BEGIN_LINK_NEGOTIATION);
      rsp_r[16 + RB_C107] <= c107_req;
      if (rx_pend_r) begin
        rsp_r[16 + RB_TYPE_B] <= 1'b1;
        rsp_r[15:0] <= {rx_hold_r, det_status};
      end else if (ans_pend_r) begin
        rsp_r[16 + RB_TYPE_B] <= 1'b1;
        rsp_r[16 + RB_TYPE_A] <= 1'b1;
        rsp_r[15:0] <= {ans_b1_r, ans_b2_r};
      end else begin
        rsp_r[16 + RB_TYPE_A] <= 1'b1;
        rsp_r[15:0] <= {8'h00, det_status};
      end
    end
  end

  // received byte waits for an exchange; a new byte wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pend_r <= 1'b0;
      rx_hold_r <= 8'h00;
    end else if (rx_valid) begin
      rx_pend_r <= 1'b1;
      rx_hold_r <= rx_byte;
    end else if (exch) begin
      rx_pend_r <= 1'b0;
    end
  end

  // answers for query commands; kept while received data has priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ans_pend_r <= 1'b0;
      ans_b1_r <= 8'h00;
      ans_b2_r <= 8'h00;
    end else if (exch) begin
      case (kind)
        C_RD_PTR: begin
          ans_pend_r <= 1'b1;
          ans_b1_r <= mif.rdata0[7:0];
          ans_b2_r <= mif.rdata0[15:8];
        end
        C_RD_PAIR: begin
          ans_pend_r <= 1'b1;
          ans_b1_r <= mif.rdata0[15:8];
          ans_b2_r <= mif.rdata1[15:8];
        end
        C_FE_RD_A, C_FE_RD_B: begin
          ans_pend_r <= 1'b1;
          ans_b1_r <= (kind == C_FE_RD_A) ? fe_read_a[7:0] : fe_read_b[7:0];
          ans_b2_r <= {4'h0, (kind == C_FE_RD_A) ? fe_read_a[11:8]
                                                 : fe_read_b[11:8]};
        end
        default: begin
          if (!rx_pend_r) begin
            ans_pend_r <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= PH_CALL;
      hs_fail_r <= 1'b0;
    end else if (exch && kind == C_INIT) begin
      phase_r <= PH_CALL;
      hs_fail_r <= 1'b0;
    end else if (exch && (kind == C_BEGIN_LINK_NEGOTIATION || kind == C_RESTART_TRAINING_CMD)) begin
      phase_r <= PH_BEGIN_LINK_NEGOTIATION;
      hs_fail_r <= 1'b0;
    end else begin
      case (phase_r)
        PH_BEGIN_LINK_NEGOTIATION: begin
          if (hs_fail) begin
            phase_r <= PH_CALL;
            hs_fail_r <= 1'b1;
          end else if (hs_done) begin
            phase_r <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (far_retrain) begin
            phase_r <= PH_BEGIN_LINK_NEGOTIATION;
          end
        end
        default: phase_r <= phase_r;
      endcase
    end
  end

  assign phase = phase_r;

  // one-cycle command strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_start <= 1'b0;
      retrain_start <= 1'b0;
      fax_sync <= 1'b0;
      fax_stop <= 1'b0;
      send_valid <= 1'b0;
      send_bytes <= 16'h0000;
      fe_cfg_stb <= 1'b0;
      fe_wr_a_stb <= 1'b0;
      fe_wr_b_stb <= 1'b0;
      fe_data <= 16'h0000;
    end else begin
      hs_start <= exch && kind == C_BEGIN_LINK_NEGOTIATION;
      retrain_start <= exch && kind == C_RESTART_TRAINING_CMD;
      fax_sync <= exch && kind == C_FAX_SYNC;
      fax_stop <= exch && kind == C_FAX_STOP;
      // parallel send refused in serial mode
      send_valid <= exch && kind == C_SEND && !serial_mode;
      fe_cfg_stb <= exch && kind == C_FE_CFG;
      fe_wr_a_stb <= exch && kind == C_FE_WR_A;
      fe_wr_b_stb <= exch && kind == C_FE_WR_B;
      if (exch && kind == C_SEND) begin
        send_bytes <= {b2, b1};
      end
      if (exch && (kind == C_FE_CFG || kind == C_FE_WR_A ||
                   kind == C_FE_WR_B)) begin
        fe_data <= {b1, b2};
      end
    end
  end

  // settings hold on no-op, default on init
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ec_freeze <= 1'b0;
      eq_freeze <= 1'b0;
      scram_tx_en <= 1'b1;
      scram_rx_en <= 1'b1;
      serial_mode <= 1'b0;
      serial_cfg <= 16'h0000;
      mode_sel <= MODE_HIGH;
      mode_cfg <= 16'h0000;
      tone_sel <= 8'h00;
      gen1_inc <= 16'h0000;
      gen2_inc <= 16'h0000;
      gen_en <= 2'b00;
      gen1_atten_db <= 4'h0;
    end else if (exch && kind == C_INIT) begin
      ec_freeze <= 1'b0;
      eq_freeze <= 1'b0;
      scram_tx_en <= 1'b1;
      scram_rx_en <= 1'b1;
      serial_mode <= 1'b0;
      serial_cfg <= 16'h0000;
      mode_sel <= MODE_HIGH;
      mode_cfg <= 16'h0000;
      tone_sel <= 8'h00;
      gen1_inc <= 16'h0000;
      gen2_inc <= 16'h0000;
      gen_en <= 2'b00;
      gen1_atten_db <= 4'h0;
    end else if (exch) begin
      case (kind)
        C_FRZ_EC: ec_freeze <= 1'b1;
        C_UFZ_EC: ec_freeze <= 1'b0;
        C_FRZ_EQ: eq_freeze <= 1'b1;
        C_UFZ_EQ: eq_freeze <= 1'b0;
        C_SCRAM: scram_tx_en <= b1[0];
        C_SERIAL: begin
          serial_mode <= (b1 != 8'h00) || (b2 != 8'h00);
          serial_cfg <= {b1, b2};
        end
        C_CFG: begin
          case (b0)
            OP_CFG_FSK: mode_sel <= MODE_FSK;
            OP_CFG_FAX: mode_sel <= MODE_FAX;
            OP_CFG_MID: mode_sel <= MODE_MID;
            default: mode_sel <= MODE_HIGH;
          endcase
          mode_cfg <= {b1, b2};
        end
        C_TONE_SEL: tone_sel <= b1;
        C_DEF_G1: gen1_inc <= {b2, b1};
        C_DEF_G2: gen2_inc <= {b2, b1};
        C_TONE_EN: begin
          gen_en <= b1[1:0];
          gen1_atten_db <= (b1[1:0] == 2'b11) ? TONE2_LIFT_DB : 4'h0;
        end
        default: ec_freeze <= ec_freeze;
      endcase
      if (phase_r == PH_BEGIN_LINK_NEGOTIATION && hs_done) begin
        scram_tx_en <= 1'b1;
        scram_rx_en <= 1'b1;
      end
    end else if (phase_r == PH_BEGIN_LINK_NEGOTIATION && hs_done) begin
      // a command in the same cycle is not lost, but handshake end overrides a scrambler command
      scram_tx_en <= 1'b1;
      scram_rx_en <= 1'b1;
    end
  end

  logic [15:0] gain_r;
  logic signed [31:0] prod;
  assign prod = $signed(tx_sample) * $signed(gain_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_r <= GAIN_RST;
      tx_sample_out <= 16'h0000;
    end else begin
      tx_sample_out <= prod[29:14];
      if (exch && kind == C_INIT) begin
        gain_r <= GAIN_RST;
      end else if (exch && kind == C_GAIN) begin
        gain_r <= {b2, b1};
      end
    end
  end

  // exchange period, lengthened in serial mode when serial_cfg[7:0] is nonzero
  assign ms_en = (ms_cnt_r == MS_CYC - 1);
  assign per_lim = (serial_mode && serial_cfg[7:0] != 8'h00) ?
                   32'((serial_cfg[7:0] > SER_MAX_MS) ? SER_MAX_MS
                                                      : serial_cfg[7:0]) :
                   32'(NOM_CYC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_r <= 32'h00000000;
    end else begin
      ms_cnt_r <= ms_en ? 32'h00000000 : ms_cnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_r <= 32'h00000000;
      exch_req_r <= 1'b0;
    end else begin
      if (serial_mode && serial_cfg[7:0] != 8'h00 ? ms_en : 1'b1) begin
        if (per_cnt_r >= per_lim - 32'h00000001) begin
          per_cnt_r <= 32'h00000000;
          exch_req_r <= 1'b1;
        end else begin
          per_cnt_r <= per_cnt_r + 32'h00000001;
          if (exch) begin
            exch_req_r <= 1'b0;
          end
        end
      end else if (exch) begin
        exch_req_r <= 1'b0;
      end
    end
  end

endmodule // mmci_core

// File: core/mmci_mem.sv
// parameter memory behind the pointer commands
// assumes one write port and a read of a word and its neighbour
`timescale 1ns/1ps
module mmci_mem (
  input wire logic hclk,
  mmci_mem_if.mem mif
);
  logic [15:0] mem_r [256];

  always_ff @(posedge hclk) begin
    if (mif.we) begin
      mem_r[mif.waddr] <= mif.wdata;
    end
  end

  // read is combinational so an answer is ready at the exchange itself
  assign mif.rdata0 = mem_r[mif.raddr];
  assign mif.rdata1 = mem_r[8'(mif.raddr + 8'h01)];
endmodule // mmci_mem

// File: core/mmci_mem_if.sv
// carrier between the interpreter and its parameter memory
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface mmci_mem_if;
  logic we;
  logic [7:0] waddr;
  logic [15:0] wdata;
  logic [7:0] raddr;
  logic [15:0] rdata0;
  logic [15:0] rdata1;
  modport core (output we, output waddr, output wdata, output raddr,
                input rdata0, input rdata1);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata0, output rdata1);
endinterface

// File: core/mmci_pkg.sv
// constants, register map and command codes of the mailbox interpreter
// assumes a 50 MHz core clock and a 32-bit bus slave in front of it
package mmci_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned EXCH_NOM_PER_S = 2400;
  localparam int unsigned NOM_CYC_DEF = CLK_HZ / EXCH_NOM_PER_S;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned MS_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] SER_MAX_MS = 8'h64;

  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_RSP = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;

  // status register fields
  localparam int unsigned ST_EXCH_REQ = 0;
  localparam int unsigned ST_SERIAL = 1;
  localparam int unsigned ST_PHASE_LO = 2;
  localparam int unsigned ST_HS_FAIL = 4;
  localparam int unsigned ST_ANS_PEND = 5;
  localparam int unsigned ST_RX_PEND = 6;

  // response byte 0 fields
  localparam int unsigned RB_FLAG_LO = 4;
  localparam int unsigned RB_TYPE_B = 4;
  localparam int unsigned RB_TYPE_A = 3;
  localparam int unsigned RB_BEGIN_LINK_NEGOTIATION = 1;
  localparam int unsigned RB_C107 = 0;

  // full 24-bit opcodes
  localparam logic [23:0] OP_NOP = 24'h000000;
  localparam logic [23:0] OP_INIT = 24'h0600c0;
  localparam logic [23:0] OP_BEGIN_LINK_NEGOTIATION = 24'h040000;
  localparam logic [23:0] OP_RESTART_TRAINING_CMD = 24'h050000;
  localparam logic [23:0] OP_UFZ_EC = 24'h170000;
  localparam logic [23:0] OP_FRZ_EC = 24'h160000;
  localparam logic [23:0] OP_FRZ_EQ = 24'h1b0000;
  localparam logic [23:0] OP_UFZ_EQ = 24'h1c0000;
  localparam logic [23:0] OP_FE_RD_A = 24'h080000;
  localparam logic [23:0] OP_FE_RD_B = 24'h090000;
  // short opcodes, byte 0 only
  localparam logic [7:0] OP_SEND = 8'h01;
  localparam logic [7:0] OP_GAIN = 8'h02;
  localparam logic [7:0] OP_FE_CFG = 8'h07;
  localparam logic [7:0] OP_FE_WR_A = 8'h0a;
  localparam logic [7:0] OP_FE_WR_B = 8'h0b;
  localparam logic [7:0] OP_TONE_SEL = 8'h0c;
  localparam logic [7:0] OP_TONE_EN = 8'h0d;
  localparam logic [7:0] OP_DEF_G1 = 8'h0e;
  localparam logic [7:0] OP_DEF_G2 = 8'h0f;
  localparam logic [7:0] OP_RD_PTR = 8'h10;
  localparam logic [7:0] OP_RD_PAIR = 8'h11;
  localparam logic [7:0] OP_STORE = 8'h12;
  localparam logic [7:0] OP_STORE_INC = 8'h13;
  localparam logic [7:0] OP_SERIAL = 8'h15;
  localparam logic [7:0] OP_SCRAM = 8'h18;
  localparam logic [7:0] OP_FAX_STOP = 8'h19;
  localparam logic [7:0] OP_FAX_SYNC = 8'h1a;
  localparam logic [7:0] OP_CFG_FSK = 8'h1d;
  localparam logic [7:0] OP_CFG_MID = 8'h1e;
  localparam logic [7:0] OP_CFG_FAX = 8'h1f;
  localparam logic [7:0] OP_CFG_HIGH = 8'h20;

  // gain reset value and tone two level lift
  localparam logic [15:0] GAIN_RST = 16'h4000;
  localparam logic [3:0] TONE2_LIFT_DB = 4'h2;

  typedef enum logic [1:0] {
    PH_CALL,
    PH_BEGIN_LINK_NEGOTIATION,
    PH_DATA
  } mmci_phase_t;

  typedef enum logic [1:0] {
    MODE_HIGH,
    MODE_FSK,
    MODE_FAX,
    MODE_MID
  } mmci_mode_t;

  typedef enum logic [4:0] {
    C_NOP, C_INIT, C_BEGIN_LINK_NEGOTIATION, C_RESTART_TRAINING_CMD, C_FRZ_EC, C_UFZ_EC, C_FRZ_EQ, C_UFZ_EQ,
    C_SCRAM, C_GAIN, C_FAX_SYNC, C_FAX_STOP, C_SEND, C_SERIAL, C_STORE,
    C_STORE_INC, C_RD_PTR, C_RD_PAIR, C_CFG, C_FE_CFG, C_FE_RD_A, C_FE_RD_B,
    C_FE_WR_A, C_FE_WR_B, C_TONE_SEL, C_TONE_EN, C_DEF_G1, C_DEF_G2
  } mmci_cmd_t;

endpackage

// File: verif/mmci_core_sva.sv
// checker for the mailbox interpreter, sees the core's ports only
// assumes a single clock domain and a one-slave ahb-lite bus
`timescale 1ns/1ps
module mmci_core_chk
  import mmci_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [1:0] phase,
  input wire logic hs_start,
  input wire logic retrain_start,
  input wire logic far_retrain,
  input wire logic hs_done,
  input wire logic hs_fail,
  input wire logic scram_tx_en,
  input wire logic scram_rx_en,
  input wire logic serial_mode,
  input wire logic send_valid,
  input wire logic fe_cfg_stb,
  input wire logic [15:0] fe_data,
  input wire logic [15:0] gen1_inc,
  input wire logic [1:0] gen_en,
  input wire logic [3:0] gen1_atten_db
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // high while a command write is in its data phase
  logic wq;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wq <= 1'b0;
    else wq <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFF_CMD;
  end
  a_done_to_data: assert property (phase == 2'd1 && hs_done && !hs_fail
    |=> phase == 2'd2) else $error("handshake end missed data phase");
  a_far_retrain: assert property (phase == 2'd2 && far_retrain
    |=> phase == 2'd1) else $error("far retrain missed handshake");
  a_scram_on_end: assert property (phase == 2'd2 && $past(phase) == 2'd1
    |-> scram_tx_en && scram_rx_en) else $error("scramblers off after handshake");
  a_no_send_serial: assert property (send_valid |-> !$past(serial_mode))
    else $error("parallel send in serial mode");
  a_fe_cfg_pass: assert property (wq && hwdata[23:16] == OP_FE_CFG
    |=> fe_cfg_stb && fe_data == $past(hwdata[15:0])) else $error("front-end cfg");
  a_tone_define: assert property (wq && hwdata[23:16] == OP_DEF_G1
    |=> gen1_inc == {$past(hwdata[7:0]), $past(hwdata[15:8])} && $stable(gen_en))
    else $error("tone one define");
  a_nop_quiet: assert property (wq && hwdata[23:0] == OP_NOP
    |=> !hs_start && !fe_cfg_stb && $stable(gen_en)) else $error("no-op acted");
  a_tone_levels: assert property (gen1_atten_db ==
    (gen_en == 2'b11 ? 4'h2 : 4'h0)) else $error("tone level");
  a_restart_training_cmd_phase: assert property (retrain_start |-> ##[0:1] phase == 2'd1)
    else $error("retrain without handshake");
  c_hs_end: cover property (phase == 2'd1 && hs_done);
  c_send: cover property (send_valid);
  c_both_gens: cover property (gen_en == 2'b11);
endmodule // mmci_core_chk
bind mmci_core mmci_core_chk chk_u (.*);

// File: verif/mmci_modem_model.sv
// handshake engine model on the far side of the interpreter
// assumes go pulses when a handshake or retrain starts
`timescale 1ns/1ps
module mmci_modem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic fail,
  input wire logic [7:0] dly,
  output logic hs_done,
  output logic hs_fail
);
  logic [7:0] cnt_r;
  logic run_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
      hs_done <= 1'b0;
      hs_fail <= 1'b0;
    end else begin
      hs_done <= 1'b0;
      hs_fail <= 1'b0;
      if (go) begin
        run_r <= 1'b1;
        cnt_r <= dly;
      end else if (run_r && cnt_r == 8'h00) begin
        run_r <= 1'b0;
        hs_done <= 1'b1;
        hs_fail <= fail;
      end else if (run_r) cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // mmci_modem_model

// File: verif/modem_mailbox_command_interpreter_test.sv
// testbench: ahb-lite host driving mailbox commands
// assumes the core and the handshake engine model
`timescale 1ns/1ps
module modem_mailbox_command_interpreter_test;
  import mmci_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [1:0] htrans = 0, phase, mode_sel, gen_en;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic hreadyout, hresp, rx_valid = 0, far_retrain = 0, fail = 0, c107_req = 0;
  logic hs_done, hs_fail, hs_start, retrain_start, ec_freeze, eq_freeze;
  logic scram_tx_en, scram_rx_en, fax_sync, fax_stop, serial_mode, send_valid;
  logic fe_cfg_stb, fe_wr_a_stb, fe_wr_b_stb;
  logic [7:0] rx_byte = 0, det_status = 0, dly = 8'd3, tone_sel;
  logic [3:0] line_flags = 0, gen1_atten_db;
  logic [11:0] fe_read_a = 0, fe_read_b = 0;
  logic [15:0] tx_sample = 16'h1000, tx_sample_out, serial_cfg, send_bytes;
  logic [15:0] mode_cfg;
  logic [15:0] fe_data, gen1_inc, gen2_inc;
  logic [7:0] ops [4] = '{8'h16, 8'h1b, 8'h17, 8'h1c};
  logic [1:0] frz [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  int miscompares = 0, checks_done = 0;
  assign hready = hreadyout;
  mmci_core #(.MS_CYC(10), .NOM_CYC(20)) dut_u (.*);
  mmci_modem_model mdl_u (.go(hs_start | retrain_start | far_retrain), .*);
  initial forever #10 hclk = ~hclk;
  task chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task xfer(logic [7:0] a, logic w, logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task cmd(logic [23:0] op);
    xfer(OFF_CMD, 1'b1, {8'h00, op});
    #1;
  endtask
  task ans(string n, logic [17:0] e);
    cmd(OP_NOP);
    xfer(OFF_RSP, 1'b0, 0);
    chk(n, {r[20:19], r[15:0]}, e);
  endtask
  task wph(logic [1:0] p);
    for (int i = 0; i < 80 && phase !== p; i++) @(posedge hclk);
    #1;
    chk("phase", phase, p);
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("scram", {scram_tx_en, scram_rx_en, phase}, 4'hc);
    xfer(8'h0c, 1'b0, 0);
    chk("unmapped", r, 0);
    cmd(24'h101000);
    cmd(OP_NOP);
    cmd(24'h133412);
    cmd(24'h12cdab);
    cmd(24'h111000);
    ans("pair", {2'b11, 16'h12ab});
    cmd(24'h127856);
    cmd(24'h101100);
    ans("word", {2'b11, 16'hcdab});
    cmd(24'h101000);
    @(posedge hclk) rx_valid <= 1'b1;
    rx_byte <= 8'h5a;
    @(posedge hclk) rx_valid <= 1'b0;
    ans("rx", {2'b10, 16'h5a00});
    ans("answer", {2'b11, 16'h7856});
    det_status <= 8'h3c;
    ans("status", {2'b01, 16'h003c});
    fe_read_a <= 12'habc;
    fe_read_b <= 12'h123;
    cmd(OP_FE_RD_A);
    ans("fe_a", {2'b11, 16'hbc0a});
    cmd(OP_FE_RD_B);
    ans("fe_b", {2'b11, 16'h2301});
    cmd(24'h0a1234);
    chk("fe_wr", {fe_wr_a_stb, fe_data}, 17'h11234);
    cmd(24'h07abcd);
    chk("fe_cfg", {fe_cfg_stb, fe_data}, 17'h1abcd);
    cmd(24'h0b5678);
    chk("fe_wr_b", {fe_wr_b_stb, fe_data}, 17'h15678);
    $display("test memory and front end done");
    cmd(24'h0c1000);
    chk("tone", {tone_sel, gen_en}, 10'h040);
    cmd(24'h0e3412);
    cmd(24'h0fff7f);
    chk("incs", {gen1_inc, gen2_inc}, 32'h12347fff);
    for (int i = 0; i < 4; i++) begin
      cmd({8'h0d, 6'h0, i[1:0], 8'h00});
      chk("gens", {gen_en, gen1_atten_db}, {i[1:0], i == 3 ? 4'h2 : 4'h0});
    end
    cmd(24'h0d0000);
    for (int i = 0; i < 4; i++) begin
      cmd({ops[i], 16'h0});
      chk("frz", {ec_freeze, eq_freeze}, frz[i]);
      cmd({i == 0 ? 8'h20 : i == 1 ? 8'h1d : i == 2 ? 8'h1f : 8'h1e, 16'h0});
      chk("mode", mode_sel, i);
    end
    cmd(24'h3f1234);
    chk("unknown", {gen1_inc, mode_sel}, 18'h048d3);
    $display("test tones and modes done");
    cmd(24'h150064);
    cmd(24'h01aabb);
    chk("ser", {serial_mode, send_valid, serial_cfg}, 18'h20064);
    // slow period: no new exchange request within two nominal periods
    repeat (40) @(posedge hclk);
    xfer(OFF_STAT, 1'b0, 0);
    chk("slow", r[1:0], 2'b10);
    cmd(24'h150000);
    cmd(24'h01aabb);
    chk("send", {send_valid, send_bytes}, 17'h1bbaa);
    cmd(24'h1a0000);
    chk("sync", fax_sync, 1);
    cmd(24'h190000);
    chk("stop", fax_stop, 1);
    cmd(24'h020020);
    @(posedge hclk);
    #1;
    chk("gain", tx_sample_out, 16'h0800);
    $display("test data and fax done");
    cmd(24'h180000);
    chk("scram_off", scram_tx_en, 0);
    cmd(OP_BEGIN_LINK_NEGOTIATION);
    wph(2'd1);
    wph(2'd2);
    chk("scram_on", {scram_tx_en, scram_rx_en}, 2'b11);
    dly <= 8'd40;
    @(posedge hclk) far_retrain <= 1'b1;
    @(posedge hclk) far_retrain <= 1'b0;
    wph(2'd1);
    wph(2'd2);
    fail <= 1'b1;
    cmd(OP_RESTART_TRAINING_CMD);
    chk("retrain", retrain_start, 1);
    wph(2'd0);
    xfer(OFF_STAT, 1'b0, 0);
    chk("hs_fail", r[4], 1);
    cmd(OP_INIT);
    chk("init", {mode_sel, gen1_inc, tone_sel, phase}, 0);
    @(posedge hclk);
    #1;
    chk("gain_rst", tx_sample_out, 16'h1000);
    $display("test handshake and init done");
    end_sim;
  end
endmodule // modem_mailbox_command_interpreter_test
